// ---- rtl/ejl_regs.svh ----
/*
  Offsets, field positions, reset values and timing counts of the ejector link.
  Assumes a 50 MHz pclk; included by bare name from the rtl files.
*/
`ifndef EJL_REGS_SVH
`define EJL_REGS_SVH
`define EJL_CLK_HZ 50000000
`define EJL_COM2_BAUD 38400
`define EJL_BIT_CYC ((`EJL_CLK_HZ + `EJL_COM2_BAUD - 1) / `EJL_COM2_BAUD)
`define EJL_FRAME_BITS 11
`define EJL_LOSS_S 3
`define EJL_LOSS_CYC (`EJL_LOSS_S * `EJL_CLK_HZ)
`define EJL_FLASH_HZ 2
`define EJL_FLASH_HALF_CYC (`EJL_CLK_HZ / (2 * `EJL_FLASH_HZ))
`define EJL_IN_BYTES_R11 15
`define EJL_OUT_BYTES_R11 4
`define EJL_RST_SP1 16'h02ee
`define EJL_RST_RP1 16'h0258
`define EJL_RST_PART_PRESENT 16'h0226
`define EJL_RST_RP2 16'h021c
`define EJL_IDX_PART_PRESENT 2
`define EJL_OB_SUCK 0
`define EJL_OB_BLOW 1
`define EJL_OB_SETTING 2
`define EJL_OB_PROF_LO 4
`define EJL_A_CTRL 12'h000
`define EJL_A_PDOUT 12'h004
`define EJL_A_CMD 12'h008
`define EJL_A_STATUS 12'h00c
`define EJL_A_MASK 12'h010
`define EJL_A_ISDU_RD 12'h014
`define EJL_A_PDIN0 12'h020
`define EJL_A_PDIN3 12'h02c
`define EJL_ST_PD 0
`define EJL_ST_ISDU 1
`define EJL_ST_MODE 2
`endif

// ---- rtl/ejl_pkg.sv ----
/*
  Types of the device end of the ejector link, also used by the bench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ejl_pkg;
  typedef enum logic [1:0] {
    EJL_SIO = 2'b01,
    EJL_IOL = 2'b10
  } ejl_mode_e;
  typedef enum logic [3:0] {
    EJL_BLUE = 4'b0001,
    EJL_GREEN = 4'b0010,
    EJL_ORANGE = 4'b0100,
    EJL_RED = 4'b1000
  } ejl_color_e;
  typedef enum logic [1:0] {
    EJL_NFC_READ = 2'h0,
    EJL_NFC_WRITE = 2'h1,
    EJL_NFC_PROCESS = 2'h2
  } ejl_nfc_e;
  typedef logic [15:0][15:0] ejl_prm_t;
endpackage

// ---- rtl/ejl_link_if.sv ----
/*
  Point-to-point link between one master port and one ejector device.
  Assumes both ends run on the same pclk.
*/
interface ejl_link_if;
  logic wake;
  logic rev11;
  logic pd_req;
  logic [31:0] pd_out;
  logic pd_ack;
  logic [119:0] pd_in;
  logic isdu_req;
  logic isdu_wr;
  logic [3:0] isdu_idx;
  logic [15:0] isdu_wdata;
  logic isdu_ack;
  logic [15:0] isdu_rdata;
  logic iol_mode;
  modport master (output wake, rev11, pd_req, pd_out, isdu_req, isdu_wr, isdu_idx, isdu_wdata,
    input pd_ack, pd_in, isdu_ack, isdu_rdata, iol_mode);
  modport device (input wake, rev11, pd_req, pd_out, isdu_req, isdu_wr, isdu_idx, isdu_wdata,
    output pd_ack, pd_in, isdu_ack, isdu_rdata, iol_mode);
endinterface

// ---- rtl/ejl_device.sv ----
/*
  Ejector device end: valve mapping, three status lamps, SIO/link mode,
  process data sizing, parameter access from link and near-field side.
  Assumes synchronous inputs on pclk and a link partner per ejl_link_if.
*/
`include "ejl_regs.svh"
// Operation
// - Open variant: command stops vacuum.
// - Closed variant: command starts vacuum.
// - Blow-off lamp orange while blowing.
// - State lamp colours; flash in setting mode.
// - Pick-up lamp orange while sucking.
// - Start in SIO mode after power-up.
// - Master may switch to link mode anytime.
// - Revision 1.1: fifteen in, four out.
// - Revision 1.0: one byte each way.
// - Process data paced at COM2 rate.
// - Parameter data only answers master requests.
// - One device per master port.
// - Near-field rejects process control commands.
// - Browser near-field access is read only.
// - SIO mode uses base profile.
// - Power loss soon after write: data-loss error; here only near-field writes arm it, not link writes.
// - Green only without error or warning.
module ejl_device #(
  parameter int LOSS_CYC = `EJL_LOSS_CYC,
  parameter int FLASH_HALF_CYC = `EJL_FLASH_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  ejl_link_if.device link,
  input wire logic variant_nc,
  input wire logic sio_suck,
  input wire logic sio_blow,
  input wire logic [15:0] vacuum,
  input wire logic warning,
  input wire logic error,
  input wire logic pwr_fail,
  input wire logic loss_clr,
  input wire logic nfc_req,
  input wire ejl_pkg::ejl_nfc_e nfc_kind,
  input wire logic nfc_app,
  input wire logic [3:0] nfc_idx,
  input wire logic [15:0] nfc_wdata,
  output logic nfc_ack,
  output logic nfc_rej,
  output logic [15:0] nfc_rdata,
  output logic valve_on,
  output logic lamp_blow,
  output logic lamp_pick,
  output ejl_pkg::ejl_color_e lamp_state,
  output logic lamp_state_on,
  output logic data_loss_error
);
  typedef struct packed {
    ejl_pkg::ejl_mode_e mode;
    logic rev11;
    logic [31:0] pd_out;
    logic pd_ack;
    logic [119:0] pd_in;
    logic isdu_ack;
    logic [15:0] isdu_rdata;
    ejl_pkg::ejl_prm_t prm;
    logic nfc_ack;
    logic nfc_rej;
    logic [15:0] nfc_rdata;
    logic [31:0] loss_cnt;
    logic loss_err;
    logic [31:0] flash_cnt;
    logic flash;
    logic valve;
    logic blow;
    logic pick;
    ejl_pkg::ejl_color_e color;
    logic color_on;
  } ejl_dev_s;

  ejl_dev_s state_reg;
  ejl_dev_s state_next;
  logic suck;
  logic blow;
  logic setting;
  logic [1:0] prof;
  logic [15:0] thr;
  logic part_present;

  always_comb begin
    if (state_reg.mode == ejl_pkg::EJL_IOL) begin
      suck = state_reg.pd_out[`EJL_OB_SUCK];
      blow = state_reg.pd_out[`EJL_OB_BLOW];
      setting = state_reg.pd_out[`EJL_OB_SETTING];
      prof = state_reg.rev11 ? state_reg.pd_out[`EJL_OB_PROF_LO+:2] : 2'h0;
    end else begin
      suck = sio_suck;
      blow = sio_blow;
      setting = 1'b0;
      prof = 2'h0;
    end
    thr = state_reg.prm[{prof, 2'(`EJL_IDX_PART_PRESENT)}];
    part_present = vacuum >= thr;
  end

  always_comb begin
    state_next = state_reg;
    state_next.pd_ack = 1'b0;
    state_next.isdu_ack = 1'b0;
    state_next.nfc_ack = 1'b0;
    state_next.nfc_rej = 1'b0;
    case (state_reg.mode)
      ejl_pkg::EJL_SIO: begin
        if (link.wake) begin
          state_next.mode = ejl_pkg::EJL_IOL;
          state_next.rev11 = link.rev11;
        end
      end
      ejl_pkg::EJL_IOL: begin
        if (link.pd_req && !state_reg.pd_ack) begin
          state_next.pd_ack = 1'b1;
          state_next.pd_in = '0;
          state_next.rev11 = link.rev11;
          if (link.rev11) begin
            state_next.pd_out = link.pd_out;
            state_next.pd_in[0] = state_reg.valve;
            state_next.pd_in[1] = part_present;
            state_next.pd_in[2] = warning;
            state_next.pd_in[3] = error | state_reg.loss_err;
            state_next.pd_in[4] = state_reg.loss_err;
            state_next.pd_in[23:8] = vacuum;
          end else begin
            state_next.pd_out = {24'h0, link.pd_out[7:0]};
            state_next.pd_in[0] = state_reg.valve;
            state_next.pd_in[1] = part_present;
            state_next.pd_in[2] = warning;
            state_next.pd_in[3] = error | state_reg.loss_err;
          end
        end
        if (link.isdu_req && !state_reg.isdu_ack) begin
          state_next.isdu_ack = 1'b1;
          state_next.isdu_rdata = state_reg.prm[link.isdu_idx];
          if (link.isdu_wr) begin
            state_next.prm[link.isdu_idx] = link.isdu_wdata;
          end
        end
      end
      default: begin
        state_next.mode = ejl_pkg::EJL_SIO;
      end
    endcase
    if (state_reg.loss_cnt != 32'h0) begin
      state_next.loss_cnt = state_reg.loss_cnt - 32'h1;
    end
    if (nfc_req) begin
      if (nfc_kind == ejl_pkg::EJL_NFC_READ) begin
        state_next.nfc_ack = 1'b1;
        state_next.nfc_rdata = state_reg.prm[nfc_idx];
      end else if (nfc_kind == ejl_pkg::EJL_NFC_WRITE && nfc_app) begin
        state_next.nfc_ack = 1'b1;
        state_next.prm[nfc_idx] = nfc_wdata;
        state_next.loss_cnt = 32'(LOSS_CYC);
      end else begin
        state_next.nfc_rej = 1'b1;
      end
    end
    if (loss_clr) begin
      state_next.loss_err = 1'b0;
    end
    if (pwr_fail && state_reg.loss_cnt != 32'h0) begin
      state_next.loss_err = 1'b1;
    end
    if (state_reg.flash_cnt == 32'(FLASH_HALF_CYC - 1)) begin
      state_next.flash_cnt = 32'h0;
      state_next.flash = ~state_reg.flash;
    end else begin
      state_next.flash_cnt = state_reg.flash_cnt + 32'h1;
    end
    state_next.valve = variant_nc ? suck : ~suck;
    state_next.blow = blow;
    state_next.pick = variant_nc ? suck : ~suck;
    if (error || state_reg.loss_err) begin
      state_next.color = ejl_pkg::EJL_RED;
    end else if (warning) begin
      state_next.color = ejl_pkg::EJL_ORANGE;
    end else if (part_present) begin
      state_next.color = ejl_pkg::EJL_GREEN;
    end else begin
      state_next.color = ejl_pkg::EJL_BLUE;
    end
    state_next.color_on = setting ? state_reg.flash : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.mode <= ejl_pkg::EJL_SIO;
      state_reg.color <= ejl_pkg::EJL_BLUE;
      for (int p = 0; p < 4; p++) begin
        state_reg.prm[4*p] <= `EJL_RST_SP1;
        state_reg.prm[4*p+1] <= `EJL_RST_RP1;
        state_reg.prm[4*p+2] <= `EJL_RST_PART_PRESENT;
        state_reg.prm[4*p+3] <= `EJL_RST_RP2;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.pd_ack = state_reg.pd_ack;
  assign link.pd_in = state_reg.pd_in;
  assign link.isdu_ack = state_reg.isdu_ack;
  assign link.isdu_rdata = state_reg.isdu_rdata;
  assign link.iol_mode = state_reg.mode[1];
  assign nfc_ack = state_reg.nfc_ack;
  assign nfc_rej = state_reg.nfc_rej;
  assign nfc_rdata = state_reg.nfc_rdata;
  assign valve_on = state_reg.valve;
  assign lamp_blow = state_reg.blow;
  assign lamp_pick = state_reg.pick;
  assign lamp_state = state_reg.color;
  assign lamp_state_on = state_reg.color_on;
  assign data_loss_error = state_reg.loss_err;
endmodule

// ---- rtl/ejl_master.sv ----
/*
  Master port end: APB register set, process data cycles paced at the
  COM2 rate, parameter requests, interrupt.
  Assumes an APB master on pclk and one device on the link.
*/
`include "ejl_regs.svh"
module ejl_master (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  ejl_link_if.master link
);
  localparam int GAP_CYC = `EJL_BIT_CYC * `EJL_FRAME_BITS;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic wake;
    logic rev11;
    logic [31:0] pd_out;
    logic pd_req;
    logic [119:0] pd_in;
    logic isdu_req;
    logic isdu_wr;
    logic [3:0] isdu_idx;
    logic [15:0] isdu_wdata;
    logic [15:0] isdu_rd;
    logic [2:0] status;
    logic [2:0] mask;
    logic mode_q;
    logic [31:0] gap;
    logic irq;
  } ejl_mst_s;

  ejl_mst_s state_reg;
  ejl_mst_s state_next;
  logic acc;
  logic wr;
  logic [2:0] ev;
  logic [31:0] rd;

  always_comb begin
    state_next = state_reg;
    acc = psel && penable && state_reg.pready;
    wr = acc && pwrite;
    ev = {link.iol_mode && !state_reg.mode_q, link.isdu_ack, link.pd_ack};
    state_next.wake = 1'b0;
    state_next.mode_q = link.iol_mode;
    state_next.pready = psel && penable && !state_reg.pready;
    case (paddr)
      `EJL_A_CTRL: rd = {30'h0, state_reg.rev11, 1'b0};
      `EJL_A_PDOUT: rd = state_reg.pd_out;
      `EJL_A_STATUS: rd = {29'h0, state_reg.status};
      `EJL_A_MASK: rd = {29'h0, state_reg.mask};
      `EJL_A_ISDU_RD: rd = {16'h0, state_reg.isdu_rd};
      `EJL_A_PDIN0: rd = state_reg.pd_in[31:0];
      12'h024: rd = state_reg.pd_in[63:32];
      12'h028: rd = state_reg.pd_in[95:64];
      `EJL_A_PDIN3: rd = {8'h0, state_reg.pd_in[119:96]};
      default: rd = 32'h0;
    endcase
    if (psel && penable && !state_reg.pready && !pwrite) begin
      state_next.prdata = rd;
    end
    if (state_reg.gap != 32'h0) begin
      state_next.gap = state_reg.gap - 32'h1;
    end
    if (link.pd_ack) begin
      state_next.pd_req = 1'b0;
      state_next.pd_in = link.pd_in;
    end
    if (link.isdu_ack) begin
      state_next.isdu_req = 1'b0;
      state_next.isdu_rd = link.isdu_rdata;
    end
    if (wr) begin
      case (paddr)
        `EJL_A_CTRL: begin
          state_next.wake = pwdata[0];
          state_next.rev11 = pwdata[1];
        end
        `EJL_A_PDOUT: state_next.pd_out = pwdata;
        `EJL_A_CMD: begin
          if (pwdata[0] && !state_reg.pd_req && state_reg.gap == 32'h0) begin
            state_next.pd_req = 1'b1;
            state_next.gap = 32'(GAP_CYC * (state_reg.rev11 ?
              `EJL_IN_BYTES_R11 + `EJL_OUT_BYTES_R11 : 2));
          end
          if (pwdata[1] && !state_reg.isdu_req) begin
            state_next.isdu_req = 1'b1;
            state_next.isdu_wr = pwdata[2];
            state_next.isdu_idx = pwdata[7:4];
            state_next.isdu_wdata = pwdata[31:16];
          end
        end
        `EJL_A_STATUS: state_next.status = state_reg.status & ~pwdata[2:0];
        `EJL_A_MASK: state_next.mask = pwdata[2:0];
        default: begin
        end
      endcase
    end
    state_next.status = state_next.status | ev;
    state_next.irq = |(state_next.status & state_next.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = 1'b0;
  assign irq = state_reg.irq;
  assign link.wake = state_reg.wake;
  assign link.rev11 = state_reg.rev11;
  assign link.pd_req = state_reg.pd_req;
  assign link.pd_out = state_reg.pd_out;
  assign link.isdu_req = state_reg.isdu_req;
  assign link.isdu_wr = state_reg.isdu_wr;
  assign link.isdu_idx = state_reg.isdu_idx;
  assign link.isdu_wdata = state_reg.isdu_wdata;
endmodule

// ---- test/ejl_link_asserts.sv ----
/*
  Checker of the link between the two ends: mode entry and handshakes.
  Assumes the bench wires it to the signals of the joining interface.
*/
module ejl_link_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wake,
  input wire logic rev11,
  input wire logic pd_req,
  input wire logic pd_ack,
  input wire logic [119:0] pd_in,
  input wire logic isdu_req,
  input wire logic isdu_ack,
  input wire logic iol_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pd_go; $rose(pd_req) && iol_mode; endsequence
  sequence s_pd_end; pd_ack ##1 (!pd_ack && !pd_req); endsequence
  sequence s_isdu_go; $rose(isdu_req) && iol_mode; endsequence
  sequence s_isdu_end; isdu_ack ##1 (!isdu_ack && !isdu_req); endsequence
  property p_sio_hold; !iol_mode && !wake |=> !iol_mode; endproperty
  property p_wake_link; wake |=> iol_mode; endproperty
  property p_link_stays; iol_mode |=> iol_mode; endproperty
  property p_pd_answer; s_pd_go |=> s_pd_end; endproperty
  property p_pd_asked; pd_ack |-> pd_req && iol_mode; endproperty
  property p_isdu_answer; s_isdu_go |=> s_isdu_end; endproperty
  property p_isdu_asked; isdu_ack |-> isdu_req && iol_mode; endproperty
  property p_rev10_narrow; pd_ack && !rev11 |-> pd_in[119:8] == 112'h0; endproperty
  a_sio_hold: assert property (p_sio_hold)
    else $error("link mode without wake");
  a_wake_link: assert property (p_wake_link)
    else $error("wake not taken");
  a_link_stays: assert property (p_link_stays)
    else $error("link mode left");
  a_pd_answer: assert property (p_pd_answer)
    else $error("process data answer late");
  a_pd_asked: assert property (p_pd_asked)
    else $error("process data ack unasked");
  a_isdu_answer: assert property (p_isdu_answer)
    else $error("parameter answer late");
  a_isdu_asked: assert property (p_isdu_asked)
    else $error("parameter ack unasked");
  a_rev10_narrow: assert property (p_rev10_narrow)
    else $error("input data too wide");
endmodule

// ---- test/test_ejector_status_and_link_mode_logic.sv ----
/*
  Bench joining master and device: APB orders, device pins, link checker.
  Assumes the rtl sources and ejl_link_asserts are compiled first.
*/
`include "ejl_regs.svh"
module test_ejector_status_and_link_mode_logic;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [5:0] f; logic [15:0] vac; logic [3:0] col;} ejl_row_s;
  typedef struct {logic [1:0] k; logic app; logic [15:0] d, rd; logic [1:0] ar;} ejl_nfc_s;
  ejl_row_s rows[6] = '{'{6'h01, 16'h0, 4'h1}, '{6'h10, 16'h0, 4'h1}, '{6'h20, 16'h0226, 4'h2},
    '{6'h31, 16'h0225, 4'h1}, '{6'h2c, 16'h0300, 4'h4}, '{6'h37, 16'h0300, 4'h8}};
  ejl_nfc_s nt[5] = '{'{2'h1, 1'h0, 16'h0111, 16'h0, 2'h1}, '{2'h0, 1'h0, 16'h0, 16'h0226, 2'h2},
    '{2'h1, 1'h1, 16'h0300, 16'h0, 2'h2}, '{2'h0, 1'h1, 16'h0, 16'h0300, 2'h2},
    '{2'h2, 1'h1, 16'h0, 16'h0, 2'h1}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, prev;
  logic variant_nc, sio_suck, sio_blow, warning, error, pwr_fail, loss_clr, nfc_req, nfc_app;
  logic nfc_ack, nfc_rej, valve_on, lamp_blow, lamp_pick, lamp_state_on, data_loss_error;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] vacuum, nfc_wdata, nfc_rdata;
  logic [3:0] nfc_idx;
  ejl_pkg::ejl_nfc_e nfc_kind;
  ejl_pkg::ejl_color_e lamp_state;
  int error_cnt, num_checks, flips;
  ejl_link_if link ();
  ejl_master ejl_master_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .link(link.master));
  ejl_device #(.LOSS_CYC(50), .FLASH_HALF_CYC(4)) ejl_device_i (.pclk, .presetn,
    .link(link.device), .variant_nc, .sio_suck, .sio_blow, .vacuum, .warning, .error, .pwr_fail,
    .loss_clr, .nfc_req, .nfc_kind, .nfc_app, .nfc_idx, .nfc_wdata, .nfc_ack, .nfc_rej,
    .nfc_rdata, .valve_on, .lamp_blow, .lamp_pick, .lamp_state, .lamp_state_on, .data_loss_error);
  ejl_link_asserts ejl_link_asserts_i (.pclk(pclk), .presetn(presetn), .wake(link.wake),
    .rev11(link.rev11), .pd_req(link.pd_req), .pd_ack(link.pd_ack), .pd_in(link.pd_in),
    .isdu_req(link.isdu_req), .isdu_ack(link.isdu_ack), .iol_mode(link.iol_mode));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic lim(input int n);
    if (n >= 500) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 500);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    lim(n);
  endtask
  task automatic evt(input logic [31:0] st);
    int n = 0;
    while (irq !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    lim(n);
    apb(1'b0, `EJL_A_STATUS, 32'h0);
    chk("status", st, q);
    chk("pslverr", 32'h0, pslverr);
    apb(1'b1, `EJL_A_STATUS, st);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("irq", 32'h0, irq);
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {variant_nc, sio_suck, sio_blow, warning, error, pwr_fail, loss_clr, nfc_req, nfc_app} = '0;
    {vacuum, nfc_wdata, nfc_idx} = {16'h0, 16'h0, 4'h2};
    nfc_kind = ejl_pkg::EJL_NFC_READ;
    error_cnt = 0;
    num_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("iol_mode", 32'h0, link.iol_mode);
    foreach (rows[i]) begin
      @(posedge pclk);
      {variant_nc, sio_suck, sio_blow, warning, error} <= rows[i].f[5:1];
      vacuum <= rows[i].vac;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("valve_on", rows[i].f[0], valve_on);
      chk("lamp_pick", rows[i].f[0], lamp_pick);
      chk("lamp_blow", rows[i].f[3], lamp_blow);
      chk("lamp_state", rows[i].col, lamp_state);
      chk("lamp_state_on", 32'h1, lamp_state_on);
    end
    @(posedge pclk);
    {variant_nc, sio_suck, sio_blow, warning, error} <= 5'h10;
    foreach (nt[i]) begin
      @(posedge pclk);
      nfc_req <= 1'b1;
      nfc_kind <= ejl_pkg::ejl_nfc_e'(nt[i].k);
      nfc_app <= nt[i].app;
      nfc_wdata <= nt[i].d;
      @(posedge pclk);
      nfc_req <= 1'b0;
      @(negedge pclk);
      chk("nfc_ack_rej", nt[i].ar, {nfc_ack, nfc_rej});
      if (nt[i].k == 2'h0) begin
        chk("nfc_rdata", nt[i].rd, nfc_rdata);
      end
    end
    chk("lamp_state", 32'h2, lamp_state);
    @(posedge pclk);
    pwr_fail <= 1'b1;
    @(posedge pclk);
    pwr_fail <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("data_loss_error", 32'h1, data_loss_error);
    chk("lamp_state", 32'h8, lamp_state);
    @(posedge pclk);
    loss_clr <= 1'b1;
    @(posedge pclk);
    loss_clr <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("data_loss_error", 32'h0, data_loss_error);
    apb(1'b1, `EJL_A_MASK, 32'h7);
    apb(1'b1, `EJL_A_CTRL, 32'h3);
    evt(32'h4);
    apb(1'b1, `EJL_A_PDOUT, 32'h5);
    apb(1'b1, `EJL_A_CMD, 32'h1);
    evt(32'h1);
    apb(1'b1, `EJL_A_CMD, 32'h1);
    repeat (40) @(posedge pclk);
    chk("irq", 32'h0, irq);
    apb(1'b0, `EJL_A_PDIN0, 32'h0);
    chk("pdin0", 32'h0003_0002, q & 32'hffff_fffe);
    chk("valve_on", 32'h1, valve_on);
    chk("lamp_pick", 32'h1, lamp_pick);
    prev = lamp_state_on;
    flips = 0;
    repeat (32) begin
      @(posedge pclk);
      flips += int'(lamp_state_on !== prev);
      prev = lamp_state_on;
    end
    chk("flash_flips", 32'h8, 32'(flips));
    apb(1'b1, `EJL_A_CMD, 32'h22);
    evt(32'h2);
    apb(1'b0, `EJL_A_ISDU_RD, 32'h0);
    chk("isdu_rdata", 32'h300, q);
    apb(1'b1, `EJL_A_CMD, 32'h0250_0026);
    evt(32'h2);
    apb(1'b0, `EJL_A_ISDU_RD, 32'h0);
    chk("isdu_wr_old", 32'h300, q);
    apb(1'b1, `EJL_A_CMD, 32'h22);
    evt(32'h2);
    apb(1'b0, `EJL_A_ISDU_RD, 32'h0);
    chk("isdu_wr_new", 32'h250, q);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", 32'h0, q);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("iol_mode", 32'h0, link.iol_mode);
    apb(1'b1, `EJL_A_MASK, 32'h7);
    apb(1'b1, `EJL_A_CTRL, 32'h1);
    evt(32'h4);
    apb(1'b1, `EJL_A_PDOUT, 32'h1);
    apb(1'b1, `EJL_A_CMD, 32'h1);
    evt(32'h1);
    apb(1'b0, `EJL_A_PDIN0, 32'h0);
    chk("pdin0_narrow", 32'h0, q & 32'hffff_ff00);
    conclude();
  end
endmodule
